//--- cies_cfg.svh
`ifndef CIES_CFG_SVH
`define CIES_CFG_SVH
// Instruction encodings (12-bit word)
`define CIES_NOP 12'h000
`define CIES_OPTION 12'h002
`define CIES_SLEEP 12'h003
`define CIES_MASK_LIT 12'hf00
`define CIES_LDLIT 12'hc00
`define CIES_RETLIT 12'h800
`define CIES_MASK_FD 12'hfc0
`define CIES_SUB 12'h080
`define CIES_RLC 12'h340
// Operand fields
`define CIES_LIT_HI 7
`define CIES_DEST_BIT 5
`define CIES_FADDR_HI 4
// Widths and reset values
`define CIES_PC_W 11
`define CIES_ACC_RST 8'h00
`define CIES_OPT_RST 8'hff
`define CIES_PC_RST 11'h000
`define CIES_ONE_PC 11'h001
`define CIES_WDT_ZERO 8'h00
`define CIES_NIB 4
`endif

//--- cies_pkg.sv
package cies_pkg;
  // Decoded operation class
  typedef enum logic [6:0] {
    CIES_OP_NOP = 7'h01,
    CIES_OP_LDLIT = 7'h02,
    CIES_OP_OPT = 7'h04,
    CIES_OP_RET = 7'h08,
    CIES_OP_SLP = 7'h10,
    CIES_OP_RLC = 7'h20,
    CIES_OP_SUB = 7'h40
  } cies_op_t;
  // Core sequencing states
  typedef enum logic [2:0] {
    CIES_RUN = 3'h1,
    CIES_FLUSH = 3'h2,
    CIES_SLEEP = 3'h4
  } cies_state_t;
endpackage

//--- cies_dec_if.sv
`timescale 1ns/1ps
// Decoded instruction fields passed from decoder to core
interface cies_dec_if;
  import cies_pkg::*;
  cies_op_t op;
  logic [7:0] lit;
  logic [4:0] faddr;
  logic dest;
  modport dec (output op, lit, faddr, dest);
  modport core (input op, lit, faddr, dest);
endinterface

//--- cies_decoder.sv
`timescale 1ns/1ps
`include "cies_cfg.svh"
// Combinational decode of the instruction word
module cies_decoder
  import cies_pkg::*;
(
  // Instruction word
  input wire logic [11:0] instr_i,
  // Decoded fields
  cies_dec_if.dec dec
);
  // ****************************************
  // Decode
  // ****************************************
  always_comb
  begin
    dec.lit = instr_i[`CIES_LIT_HI:0];
    dec.faddr = instr_i[`CIES_FADDR_HI:0];
    dec.dest = instr_i[`CIES_DEST_BIT];
    if ((instr_i & `CIES_MASK_LIT) == `CIES_LDLIT)
      dec.op = CIES_OP_LDLIT;
    else if ((instr_i & `CIES_MASK_LIT) == `CIES_RETLIT)
      dec.op = CIES_OP_RET;
    else if ((instr_i & `CIES_MASK_FD) == `CIES_SUB)
      dec.op = CIES_OP_SUB;
    else if ((instr_i & `CIES_MASK_FD) == `CIES_RLC)
      dec.op = CIES_OP_RLC;
    else if (instr_i == `CIES_OPTION)
      dec.op = CIES_OP_OPT;
    else if (instr_i == `CIES_SLEEP)
      dec.op = CIES_OP_SLP;
    else
      dec.op = CIES_OP_NOP; // Unknown words act as no-operation
  end
endmodule // cies_decoder

//--- cies_alu.sv
`timescale 1ns/1ps
`include "cies_cfg.svh"
// Rotate-left-through-carry and subtract datapath
module cies_alu
  import cies_pkg::*;
(
  // Operands
  input wire logic [7:0] file_i,
  input wire logic [7:0] acc_i,
  input wire logic carry_i,
  // Results
  output logic [7:0] rot_o,
  output logic rot_c_o,
  output logic [7:0] sub_o,
  output logic sub_c_o,
  output logic sub_dc_o,
  output logic sub_z_o
);
  logic [8:0] diff; // Sum with inverted accumulator
  logic [4:0] ndiff; // Low nibble sum
  // ****************************************
  // Arithmetic
  // ****************************************
  always_comb
  begin
    rot_o = {file_i[6:0], carry_i}; // RULE_08
    rot_c_o = file_i[7]; // RULE_08
    diff = {1'b0, file_i} + {1'b0, ~acc_i} + 9'h001; // RULE_09
    ndiff = {1'b0, file_i[`CIES_NIB-1:0]} + {1'b0, ~acc_i[`CIES_NIB-1:0]} + 5'h01;
    sub_o = diff[7:0];
    sub_c_o = diff[8]; // RULE_09
    sub_dc_o = ndiff[`CIES_NIB]; // RULE_09
    sub_z_o = (diff[7:0] == 8'h00); // RULE_09
  end
endmodule // cies_alu

//--- cies_core.sv
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
`include "cies_cfg.svh"
// Operation
// [RULE_01] Load literal into accumulator, flags kept
// [RULE_02] Copy accumulator into option register
// [RULE_03] Return: literal to accumulator, pop stack
// [RULE_04] Return takes two cycles, flush fetched
// [RULE_05] Sleep clears watchdog and its prescaler
// [RULE_06] Sleep sets expiry, clears powerdown flag
// [RULE_07] Sleep halts until a wake event
// [RULE_08] Rotate file left through carry only
// [RULE_09] Subtract accumulator from file, set C/DC/Z
// [RULE_10] Destination bit picks accumulator or file
// [RULE_11] No-operation changes only the program counter
module cies_core
  import cies_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction fetch
  input wire logic [11:0] instr_i,
  output logic [`CIES_PC_W-1:0] pc_o,
  output logic exec_o,
  // Call stack
  input wire logic [`CIES_PC_W-1:0] stack_top_i,
  output logic stack_pop_o,
  // File register port
  input wire logic [7:0] file_rdata_i,
  output logic [4:0] file_addr_o,
  output logic [7:0] file_wdata_o,
  output logic file_we_o,
  // Core state
  output logic [7:0] acc_o,
  output logic [7:0] option_o,
  output logic carry_flag_o,
  output logic digit_carry_flag_o,
  output logic zero_flag_o,
  output logic watchdog_expiry_flag_n_o,
  output logic powerdown_flag_n_o,
  input wire logic pin_change_wake_flag_i,
  output logic pin_change_wake_flag_o,
  // Watchdog
  output logic watchdog_clear_o,
  output logic sleeping_o,
  // Wake-up pin
  input wire logic wake_i
);
  // Decoded fields
  cies_dec_if dec_if ();
  // Datapath results
  logic [7:0] rot_res;
  logic rot_c;
  logic [7:0] sub_res;
  logic sub_c;
  logic sub_dc;
  logic sub_z;
  // State registers
  cies_state_t state_q, state_d;
  logic [`CIES_PC_W-1:0] pc_q, pc_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] opt_q, opt_d;
  logic c_q, c_d;
  logic dc_q, dc_d;
  logic z_q, z_d;
  logic to_n_q, to_n_d;
  logic pd_n_q, pd_n_d;
  logic pcw_q, pcw_d;
  logic wclr_q, wclr_d;
  logic pop_q, pop_d;
  logic exec_q, exec_d;
  logic fwe_q, fwe_d;
  logic [4:0] faddr_q, faddr_d;
  logic [7:0] fdat_q, fdat_d;
  logic slp_q, slp_d; // Registered sleep indication
  // Wake synchroniser
  logic wake_s1_q, wake_s2_q;
  logic run_cycle;
  logic wb_hold; // Write-back owns the file port while the current word reads the file

  // ****************************************
  // Submodules
  // ****************************************
  cies_decoder u_dec (
    .instr_i(instr_i),
    .dec(dec_if.dec)
  );

  cies_alu u_alu (
    .file_i(file_rdata_i),
    .acc_i(acc_q),
    .carry_i(c_q),
    .rot_o(rot_res),
    .rot_c_o(rot_c),
    .sub_o(sub_res),
    .sub_c_o(sub_c),
    .sub_dc_o(sub_dc),
    .sub_z_o(sub_z)
  );

  // ****************************************
  // Wake pin synchroniser
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end
    else
    begin
      wake_s1_q <= wake_i;
      wake_s2_q <= wake_s1_q;
    end
  end

  // A file read right behind a registered write-back must wait one cycle:
  // the single file port carries the write address while the strobe stands
  assign wb_hold = fwe_q && (dec_if.op == CIES_OP_RLC || dec_if.op == CIES_OP_SUB); // RULE_10
  assign run_cycle = (state_q == CIES_RUN) && !wb_hold;
  // Write-back address while the write strobe stands, else the read address
  assign file_addr_o = fwe_q ? faddr_q : dec_if.faddr; // RULE_10

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    pc_d = pc_q;
    acc_d = acc_q;
    opt_d = opt_q;
    c_d = c_q;
    dc_d = dc_q;
    z_d = z_q;
    to_n_d = to_n_q;
    pd_n_d = pd_n_q;
    pcw_d = pin_change_wake_flag_i; // Wake flag tracked, never altered here
    wclr_d = 1'b0;
    pop_d = 1'b0;
    exec_d = 1'b0;
    fwe_d = 1'b0;
    faddr_d = faddr_q;
    fdat_d = fdat_q;
    case (state_q)
      CIES_RUN:
      begin
        exec_d = 1'b1;
        pc_d = pc_q + `CIES_ONE_PC; // RULE_11
        case (dec_if.op)
          CIES_OP_NOP:
          begin
            pc_d = pc_q + `CIES_ONE_PC; // RULE_11
          end
          CIES_OP_LDLIT:
          begin
            acc_d = dec_if.lit; // RULE_01
          end
          CIES_OP_OPT:
          begin
            opt_d = acc_q; // RULE_02
          end
          CIES_OP_RET:
          begin
            acc_d = dec_if.lit; // RULE_03
            pc_d = stack_top_i; // RULE_03
            pop_d = 1'b1; // RULE_03
            state_d = CIES_FLUSH; // RULE_04
          end
          CIES_OP_SLP:
          begin
            wclr_d = 1'b1; // RULE_05
            to_n_d = 1'b1; // RULE_06
            pd_n_d = 1'b0; // RULE_06
            pc_d = pc_q + `CIES_ONE_PC;
            state_d = CIES_SLEEP; // RULE_07
          end
          CIES_OP_RLC:
          begin
            c_d = rot_c; // RULE_08
            if (dec_if.dest) // RULE_10
            begin
              fwe_d = 1'b1;
              faddr_d = dec_if.faddr;
              fdat_d = rot_res;
            end
            else
              acc_d = rot_res; // RULE_10
          end
          CIES_OP_SUB:
          begin
            c_d = sub_c; // RULE_09
            dc_d = sub_dc; // RULE_09
            z_d = sub_z; // RULE_09
            if (dec_if.dest) // RULE_10
            begin
              fwe_d = 1'b1;
              faddr_d = dec_if.faddr;
              fdat_d = sub_res;
            end
            else
              acc_d = sub_res; // RULE_10
          end
          default:
          begin
            pc_d = pc_q + `CIES_ONE_PC;
          end
        endcase
      end
      CIES_FLUSH:
      begin
        // Discard the word fetched before the reload
        state_d = CIES_RUN; // RULE_04
      end
      CIES_SLEEP:
      begin
        // Nothing executes until a synchronised wake
        if (wake_s2_q) // RULE_07
          state_d = CIES_RUN;
      end
      default:
      begin
        state_d = CIES_RUN;
      end
    endcase
    // Hold back a file read while the write-back owns the port
    if (state_q == CIES_RUN && wb_hold) // RULE_10
    begin
      state_d = state_q;
      pc_d = pc_q;
      acc_d = acc_q;
      c_d = c_q;
      dc_d = dc_q;
      z_d = z_q;
      exec_d = 1'b0;
      fwe_d = 1'b0;
      faddr_d = faddr_q;
      fdat_d = fdat_q;
    end
    // Sleep output follows the next state so it stands with the state register
    slp_d = (state_d == CIES_SLEEP); // RULE_07
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= CIES_RUN;
      pc_q <= `CIES_PC_RST;
      acc_q <= `CIES_ACC_RST;
      opt_q <= `CIES_OPT_RST;
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
      to_n_q <= 1'b1;
      pd_n_q <= 1'b1;
      pcw_q <= 1'b0;
      slp_q <= 1'b0;
      wclr_q <= 1'b0;
      pop_q <= 1'b0;
      exec_q <= 1'b0;
      fwe_q <= 1'b0;
      faddr_q <= 5'h00;
      fdat_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      pc_q <= pc_d;
      acc_q <= acc_d;
      opt_q <= opt_d;
      c_q <= c_d;
      dc_q <= dc_d;
      z_q <= z_d;
      to_n_q <= to_n_d;
      pd_n_q <= pd_n_d;
      pcw_q <= pcw_d;
      slp_q <= slp_d;
      wclr_q <= wclr_d;
      pop_q <= pop_d;
      exec_q <= exec_d;
      fwe_q <= fwe_d;
      faddr_q <= faddr_d;
      fdat_q <= fdat_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign pc_o = pc_q;
  assign exec_o = exec_q;
  assign stack_pop_o = pop_q;
  assign file_wdata_o = fdat_q;
  assign file_we_o = fwe_q;
  assign acc_o = acc_q;
  assign option_o = opt_q;
  assign carry_flag_o = c_q;
  assign digit_carry_flag_o = dc_q;
  assign zero_flag_o = z_q;
  assign watchdog_expiry_flag_n_o = to_n_q;
  assign powerdown_flag_n_o = pd_n_q;
  assign pin_change_wake_flag_o = pcw_q;
  assign watchdog_clear_o = wclr_q;
  assign sleeping_o = slp_q;

  // ****************************************
  // Assertions
  // ****************************************
  a_ldlit_acc_load: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    run_cycle && dec_if.op == CIES_OP_LDLIT |=> acc_q == $past(instr_i[7:0]) && c_q == $past(c_q)
      && z_q == $past(z_q))
    else $error("load literal result wrong");
  a_opt_copy_acc: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    run_cycle && dec_if.op == CIES_OP_OPT |=> option_o == $past(acc_q) && dc_q == $past(dc_q))
    else $error("option load wrong");
  a_ret_pop_pc: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    run_cycle && dec_if.op == CIES_OP_RET |=> pc_q == $past(stack_top_i) && stack_pop_o
      && acc_q == $past(instr_i[7:0]))
    else $error("return literal wrong");
  a_ret_two_cycles: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    run_cycle && dec_if.op == CIES_OP_RET |=> !run_cycle ##1 run_cycle && !exec_o)
    else $error("return did not flush one cycle");
  a_sleep_wdt_clear: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
    run_cycle && dec_if.op == CIES_OP_SLP |=> watchdog_clear_o ##1 !watchdog_clear_o)
    else $error("watchdog not cleared once");
  a_sleep_flags: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
    run_cycle && dec_if.op == CIES_OP_SLP |=> watchdog_expiry_flag_n_o && !powerdown_flag_n_o)
    else $error("sleep flags wrong");
  a_sleep_halts: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
    sleeping_o && !wake_s2_q |=> sleeping_o && $stable(pc_q) && $stable(acc_q))
    else $error("core ran while asleep");
  a_rot_result: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
    run_cycle && dec_if.op == CIES_OP_RLC && !dec_if.dest |=>
      acc_q == {$past(file_rdata_i[6:0]), $past(c_q)} && c_q == $past(file_rdata_i[7]) && $stable(z_q))
    else $error("rotate result wrong");
  a_sub_result: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
    run_cycle && dec_if.op == CIES_OP_SUB && !dec_if.dest |=>
      acc_q == 8'($past(file_rdata_i) - $past(acc_q)) && c_q == ($past(file_rdata_i) >= $past(acc_q))
      && z_q == (acc_q == 8'h00))
    else $error("subtract result wrong");
  a_dest_file: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
    run_cycle && (dec_if.op == CIES_OP_SUB || dec_if.op == CIES_OP_RLC) |=>
      file_we_o == $past(dec_if.dest)
      && (!file_we_o || ($stable(acc_q) && file_addr_o == $past(dec_if.faddr))))
    else $error("destination select wrong");
  a_wb_hold_read: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
    state_q == CIES_RUN && wb_hold |=> $stable(pc_q) && $stable(acc_q) && !exec_o && !file_we_o)
    else $error("file read not held behind write-back");
  a_nop_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    run_cycle && dec_if.op == CIES_OP_NOP |=> pc_q == $past(pc_q) + 11'h001 && $stable(acc_q)
      && !file_we_o && run_cycle)
    else $error("no-operation changed state");
endmodule // cies_core

//--- cies_tb.sv
`timescale 1ns/1ps
`include "cies_cfg.svh"
module tb
  import cies_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] instr_i = `CIES_NOP;
  logic [10:0] stack_top_i = 11'h5a3;
  logic [7:0] file_rdata_i = 8'h00;
  logic pin_change_wake_flag_i = 1'b1;
  logic wake_i = 1'b0;
  logic [10:0] pc_o;
  logic exec_o, stack_pop_o, file_we_o, carry_flag_o, digit_carry_flag_o, zero_flag_o;
  logic watchdog_expiry_flag_n_o, powerdown_flag_n_o, pin_change_wake_flag_o;
  logic watchdog_clear_o, sleeping_o;
  logic [4:0] file_addr_o;
  logic [7:0] file_wdata_o, acc_o, option_o;
  // Expected core state
  logic [10:0] e_pc;
  logic [7:0] e_acc, e_opt;
  logic e_c, e_dc, e_z;
  int fail_count = 0;
  int cmp_count = 0;
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  cies_core DUT (
    .clk_i(clk_i), .rst_i(rst_i), .instr_i(instr_i), .pc_o(pc_o), .exec_o(exec_o),
    .stack_top_i(stack_top_i), .stack_pop_o(stack_pop_o), .file_rdata_i(file_rdata_i),
    .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o), .file_we_o(file_we_o),
    .acc_o(acc_o), .option_o(option_o), .carry_flag_o(carry_flag_o),
    .digit_carry_flag_o(digit_carry_flag_o), .zero_flag_o(zero_flag_o),
    .watchdog_expiry_flag_n_o(watchdog_expiry_flag_n_o), .powerdown_flag_n_o(powerdown_flag_n_o),
    .pin_change_wake_flag_i(pin_change_wake_flag_i), .pin_change_wake_flag_o(pin_change_wake_flag_o),
    .watchdog_clear_o(watchdog_clear_o), .sleeping_o(sleeping_o), .wake_i(wake_i)
  );
  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset pulse, then reset values of every state output except the pin-change wake flag
  task automatic do_reset(input int n);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk(pc_o, 11'h000);
    chk(11'(acc_o), 11'h000);
    chk(11'(option_o), 11'h0ff);
    chk(11'({carry_flag_o, digit_carry_flag_o, zero_flag_o}), 11'h000);
    chk(11'({watchdog_expiry_flag_n_o, powerdown_flag_n_o}), 11'h003);
    chk(11'({exec_o, stack_pop_o, file_we_o, watchdog_clear_o, sleeping_o}), 11'h000);
    e_pc = 11'h000;
    e_acc = 8'h00;
    e_opt = 8'hff;
    {e_c, e_dc, e_z} = 3'h0;
  endtask
  // One word between idle words; expectations from the instruction set
  task automatic op(input logic [11:0] w, input logic [7:0] fv);
    logic [8:0] s;
    logic [7:0] r;
    logic fd;
    r = 8'h00;
    fd = 1'b0;
    @(posedge clk_i);
    instr_i <= w;
    file_rdata_i <= fv;
    #1 chk(11'(file_addr_o), 11'(w[4:0]));
    @(posedge clk_i);
    instr_i <= `CIES_NOP;
    e_pc = e_pc + 11'h002;
    if ((w & `CIES_MASK_LIT) == `CIES_LDLIT)
      e_acc = w[7:0];
    else if (w == `CIES_OPTION)
      e_opt = e_acc;
    else if ((w & `CIES_MASK_FD) == `CIES_RLC)
    begin
      fd = 1'b1;
      r = {fv[6:0], e_c};
      e_c = fv[7];
    end
    else if ((w & `CIES_MASK_FD) == `CIES_SUB)
    begin
      fd = 1'b1;
      s = {1'b0, fv} - {1'b0, e_acc};
      r = s[7:0];
      e_c = ~s[8];
      e_dc = (fv[3:0] >= e_acc[3:0]);
      e_z = (r == 8'h00);
    end
    // Destination bit: accumulator or file write-back
    if (fd && !w[5])
      e_acc = r;
    #1;
    chk(11'(acc_o), 11'(e_acc));
    chk(11'(option_o), 11'(e_opt));
    chk(11'({carry_flag_o, digit_carry_flag_o, zero_flag_o}), 11'({e_c, e_dc, e_z}));
    chk(pc_o, e_pc);
    chk(11'({exec_o, stack_pop_o, watchdog_clear_o}), 11'h004);
    chk(11'(file_we_o), 11'(fd & w[5]));
    if (fd & w[5])
    begin
      chk(11'(file_wdata_o), 11'(r));
      chk(11'(file_addr_o), 11'(w[4:0]));
    end
    chk(11'(pin_change_wake_flag_o), 11'(pin_change_wake_flag_i));
  endtask
  // ****************************************
  // Test sequence
  // ****************************************
  logic [7:0] lits [3] = '{8'h00, 8'hff, 8'ha5};
  logic [7:0] sf [4] = '{8'h3c, 8'h10, 8'h25, 8'h08};
  logic [7:0] sw [4] = '{8'h3c, 8'h21, 8'h13, 8'h09};
  initial
  begin
    do_reset(20);
    op(`CIES_NOP, 8'h00);
    foreach (lits[i]) op(`CIES_LDLIT | {4'h0, lits[i]}, 8'h00);
    op(`CIES_OPTION, 8'h00);
    op(`CIES_RLC | 12'h01f, 8'h81);
    op(`CIES_RLC | 12'h020, 8'h81);
    op(`CIES_RLC | 12'h025, 8'h40);
    // Write-back followed at once by a file read: the read waits one cycle
    @(posedge clk_i);
    instr_i <= `CIES_RLC | 12'h025;
    file_rdata_i <= 8'h40;
    @(posedge clk_i);
    instr_i <= `CIES_RLC | 12'h003;
    file_rdata_i <= 8'h81;
    #1 chk(11'({file_we_o, file_addr_o}), 11'h025);
    chk(11'(file_wdata_o), 11'({7'h40, e_c}));
    @(posedge clk_i);
    #1 chk(11'({exec_o, file_we_o, file_addr_o}), 11'h003);
    chk(pc_o, e_pc + 11'h002);
    @(posedge clk_i);
    instr_i <= `CIES_NOP;
    #1 chk(11'({acc_o, carry_flag_o}), 11'h005);
    e_pc = e_pc + 11'h003;
    chk(pc_o, e_pc);
    e_acc = 8'h02;
    e_c = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      op(`CIES_LDLIT | {4'h0, sw[i]}, 8'h00);
      op(`CIES_SUB | {6'h00, i[0], 5'(i * 9)}, sf[i]);
    end
    // Return followed at once by a word that must be dropped
    @(posedge clk_i);
    instr_i <= `CIES_RETLIT | 12'h096;
    @(posedge clk_i);
    instr_i <= `CIES_LDLIT | 12'h011;
    #1 chk(11'(acc_o), 11'h096);
    chk(pc_o, 11'h5a3);
    chk(11'({stack_pop_o, exec_o, carry_flag_o}), 11'({2'b11, e_c}));
    @(posedge clk_i);
    instr_i <= `CIES_NOP;
    #1 chk(11'(acc_o), 11'h096);
    chk(11'({exec_o, stack_pop_o}), 11'h000);
    chk(pc_o, 11'h5a3);
    e_acc = 8'h96;
    e_pc = 11'h5a3;
    op(`CIES_NOP, 8'h00);
    // Sleep with a live word pending, then wake
    @(posedge clk_i);
    instr_i <= `CIES_SLEEP;
    @(posedge clk_i);
    instr_i <= `CIES_LDLIT | 12'h077;
    pin_change_wake_flag_i <= 1'b0;
    #1 chk(11'(watchdog_clear_o), 11'h001);
    chk(11'({watchdog_expiry_flag_n_o, powerdown_flag_n_o}), 11'h002);
    chk(11'(sleeping_o), 11'h001);
    repeat (5) @(posedge clk_i);
    #1 chk(11'({acc_o, exec_o, watchdog_clear_o, sleeping_o}), 11'({e_acc, 3'b001}));
    chk(11'(pin_change_wake_flag_o), 11'h000);
    chk(pc_o, e_pc + 11'h002);
    @(posedge clk_i);
    wake_i <= 1'b1;
    instr_i <= `CIES_NOP;
    repeat (3) @(posedge clk_i);
    #1 chk(11'(sleeping_o), 11'h000);
    @(posedge clk_i);
    wake_i <= 1'b0;
    e_pc = e_pc + 11'h003;
    op(`CIES_LDLIT | 12'h042, 8'h00);
    chk(11'(powerdown_flag_n_o), 11'h000);
    do_reset(2);
    final_report();
  end
  // Watchdog against a hang
  initial
  begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    final_report();
  end
endmodule // tb
